// [testbench/pmc_cpu_model.sv]
// Model of the serial port and interrupt controller beside the block.
// Assumes commands arrive as one-cycle pulses on clk_sys.
`timescale 1ns/1ps

module pmc_cpu_model
	import pmc_pkg::*;
(
	input  wire logic  clk_sys,
	input  wire logic  sys_rst,
	input  wire logic  send_tx,
	input  wire logic  send_rx,
	input  wire logic  raise_int,
	output pmc_evt_type evt,
	output logic        ext_int_pending
);
	// ------------------------------------------------
	// Serial activity lasts a while after its trigger
	// ------------------------------------------------
	logic [3:0] busy_q;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			evt             <= '0;
			busy_q          <= 4'h0;
			ext_int_pending <= 1'b0;
		end else begin
			evt.tx_buf_write  <= send_tx;
			evt.rx_start_fall <= send_rx;
			evt.rx_enable     <= 1'b1;
			evt.any_int       <= raise_int;
			evt.ext_int_ack   <= raise_int;
			ext_int_pending   <= raise_int;
			busy_q            <= (send_tx || send_rx) ? 4'hf :
				busy_q - 4'(busy_q != 4'h0);
			evt.serial_busy   <= send_tx || send_rx || busy_q != 4'h0;
		end
	end
endmodule // pmc_cpu_model

// [testbench/pmc_power_ctrl_props.sv]
// Checker for the power mode and clock control block.
// Bound into pmc_power_ctrl; sees only its ports.
`timescale 1ns/1ps

module pmc_power_props
	import pmc_pkg::*;
#(
	parameter int XTAL_WARM_CLOCKS = 8
) (
	input wire logic        clk_sys,
	input wire logic        sys_rst,
	input wire logic        ext_rst_pin,
	input wire logic        wdt_timeout,
	input wire logic        wdt_clear,
	input wire logic        wdt_enable,
	input wire logic        wdt_rst_enable,
	input wire logic        ext_int_pending,
	input wire pmc_req_type req,
	input wire pmc_evt_type evt,
	input wire logic [7:0]  rdata,
	input wire logic        cpu_clk_en,
	input wire logic        periph_tick,
	input wire logic        core_tick,
	input wire logic        idle_active,
	input wire logic        addr_latch_strobe,
	input wire logic        program_store_strobe,
	input wire logic        port_hold,
	input wire logic        core_rst,
	input wire logic        skip_next_instr,
	input wire logic        osc_source_indicator,
	input wire logic        crystal_amp_disable
);
	// ------------------------------------------------
	// Helper state
	// ------------------------------------------------
	logic [10:0] wd_q, wd_d, age_q, age_d;
	logic        swb_q, swb_d;

	always_comb begin
		wd_d = wd_q;
		if (wdt_timeout && wd_q == 11'h000)
			wd_d = 11'h001;
		else if (wdt_clear || core_rst)
			wd_d = 11'h000;
		else if (wd_q != 11'h000)
			wd_d = (wd_q == 11'h258) ? 11'h000 : wd_q + 11'h001;
		age_d = (age_q == 11'h7ff) ? age_q : age_q + 11'h001;
		if (req.wr && req.addr == PMC_ADDR_EXT_INT_FLAG_REG)
			age_d = 11'h000;
		swb_d = swb_q;
		if (req.wr && req.addr == PMC_ADDR_PMR)
			swb_d = req.wdata[PMC_SWB_BIT];
		if (core_rst)
			swb_d = 1'b0;
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			wd_q  <= 11'h000;
			age_q <= 11'h7ff;
			swb_q <= 1'b0;
		end else begin
			wd_q  <= wd_d;
			age_q <= age_d;
			swb_q <= swb_d;
		end
	end

	// ------------------------------------------------
	// Properties
	// ------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	property p_idle_entry;
		req.wr && req.addr == PMC_ADDR_POWER_CONTROL_REG && req.wdata[0] && !evt.any_int
		&& !ext_int_pending && !wdt_timeout && !core_rst |=> idle_active;
	endproperty
	a_idle_entry: assert property (p_idle_entry)
		else $error("idle not entered");

	property p_idle_clk;
		idle_active |-> !cpu_clk_en && !core_tick;
	endproperty
	a_idle_clk: assert property (p_idle_clk)
		else $error("core clocked in idle");

	property p_idle_pins;
		idle_active |-> addr_latch_strobe && program_store_strobe && port_hold;
	endproperty
	a_idle_pins: assert property (p_idle_pins)
		else $error("idle pin levels wrong");

	property p_wake;
		idle_active && evt.any_int |=> !idle_active;
	endproperty
	a_wake: assert property (p_wake)
		else $error("interrupt did not end idle");

	property p_ext_rst;
		ext_rst_pin [*8] |-> ##[0:2] core_rst;
	endproperty
	a_ext_rst: assert property (p_ext_rst)
		else $error("external reset not taken");

	property p_wdt_rst;
		wd_q == 11'h200 && wdt_rst_enable |-> ##[0:3] core_rst;
	endproperty
	a_wdt_rst: assert property (p_wdt_rst)
		else $error("watchdog reset missing");

	property p_idle_tick;
		idle_active && periph_tick ##1 idle_active [*4] |-> periph_tick;
	endproperty
	a_idle_tick: assert property (p_idle_tick)
		else $error("idle peripheral rate wrong");

	property p_osc;
		$changed(osc_source_indicator) && !core_rst && !$past(core_rst)
		|-> age_q inside {[11'h001:11'h44c]};
	endproperty
	a_osc: assert property (p_osc)
		else $error("source changed without select write");

	property p_sb;
		swb_q && evt.tx_buf_write && !idle_active && !core_rst
		|-> ##[1:8] core_tick ##4 core_tick;
	endproperty
	a_sb: assert property (p_sb)
		else $error("no switchback to divide by four");

endmodule // pmc_power_props

bind pmc_power_ctrl pmc_power_props #(
	.XTAL_WARM_CLOCKS(XTAL_WARM_CLOCKS)
) props_u (
	.clk_sys              (clk_sys),
	.sys_rst              (sys_rst),
	.ext_rst_pin          (ext_rst_pin),
	.wdt_timeout          (wdt_timeout),
	.wdt_clear            (wdt_clear),
	.wdt_enable           (wdt_enable),
	.wdt_rst_enable       (wdt_rst_enable),
	.ext_int_pending      (ext_int_pending),
	.req                  (req),
	.evt                  (evt),
	.rdata                (rdata),
	.cpu_clk_en           (cpu_clk_en),
	.periph_tick          (periph_tick),
	.core_tick            (core_tick),
	.idle_active          (idle_active),
	.addr_latch_strobe    (addr_latch_strobe),
	.program_store_strobe (program_store_strobe),
	.port_hold            (port_hold),
	.core_rst             (core_rst),
	.skip_next_instr      (skip_next_instr),
	.osc_source_indicator (osc_source_indicator),
	.crystal_amp_disable  (crystal_amp_disable)
);

// [testbench/testbench.sv]
// Self-checking bench for the power mode and clock control block.
// Drives register port and watchdog; a model drives serial events.
`timescale 1ns/1ps

module testbench;
	import pmc_pkg::*;
	logic        clk_sys, sys_rst, ext_rst_pin, wdt_timeout, wdt_clear;
	logic        wdt_enable, wdt_rst_enable, ext_int_pending;
	logic        send_tx, send_rx, raise_int;
	pmc_req_type req;
	pmc_evt_type evt;
	logic [7:0]  rdata;
	logic        cpu_clk_en, periph_tick, core_tick, idle_active, port_hold;
	logic        addr_latch_strobe, program_store_strobe, core_rst;
	logic        skip_next_instr, osc_source_indicator, crystal_amp_disable;
	int          failures, check_count, tick_n, since, last_gap, rst_n, skip_n;
	logic [1:0]  cd [5] = '{2'h2, 2'h0, 2'h1, 2'h3, 2'h1};
	logic [15:0] gp [5] = '{16'h0040, 16'h0040, 16'h0004, 16'h0400, 16'h0004};

	pmc_power_ctrl #(.XTAL_WARM_CLOCKS(8)) dut_u (
		.clk_sys              (clk_sys),
		.sys_rst              (sys_rst),
		.ext_rst_pin          (ext_rst_pin),
		.wdt_timeout          (wdt_timeout),
		.wdt_clear            (wdt_clear),
		.wdt_enable           (wdt_enable),
		.wdt_rst_enable       (wdt_rst_enable),
		.ext_int_pending      (ext_int_pending),
		.req                  (req),
		.evt                  (evt),
		.rdata                (rdata),
		.cpu_clk_en           (cpu_clk_en),
		.periph_tick          (periph_tick),
		.core_tick            (core_tick),
		.idle_active          (idle_active),
		.addr_latch_strobe    (addr_latch_strobe),
		.program_store_strobe (program_store_strobe),
		.port_hold            (port_hold),
		.core_rst             (core_rst),
		.skip_next_instr      (skip_next_instr),
		.osc_source_indicator (osc_source_indicator),
		.crystal_amp_disable  (crystal_amp_disable)
	);
	pmc_cpu_model model_u (
		.clk_sys        (clk_sys),
		.sys_rst        (sys_rst),
		.send_tx        (send_tx),
		.send_rx        (send_rx),
		.raise_int      (raise_int),
		.evt            (evt),
		.ext_int_pending(ext_int_pending)
	);

	// ------------------------------------------------
	// Clock, monitors and tasks
	// ------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		since <= core_tick ? 1 : since + 1;
		if (core_tick) begin
			last_gap <= since;
			tick_n   <= tick_n + 1;
		end
		if (core_rst)
			rst_n <= rst_n + 1;
		if (skip_next_instr)
			skip_n <= skip_n + 1;
	end

	task automatic check(string what, logic [15:0] exp, logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(logic [7:0] a, logic [7:0] d);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys);
		req <= '0;
		@(posedge clk_sys);
	endtask

	task automatic rd(logic [7:0] a, logic [7:0] e, logic [7:0] m);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys);
		req <= '0;
		#1;
		check("rdata", 16'(e & m), 16'(rdata & m));
		@(posedge clk_sys);
	endtask

	// Third tick period after a change shows the settled rate
	task automatic gap(logic [15:0] e);
		int n0;
		n0 = tick_n;
		for (int k = 0; k < 4000 && tick_n < n0 + 3; k++)
			@(posedge clk_sys);
		check("ticks", 16'h0001, 16'(tick_n >= n0 + 3));
		check("gap", e, 16'(last_gap));
	endtask

	task automatic test_done();
		$display("Checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		#200000;
		failures++;
		test_done();
	end

	// ------------------------------------------------
	// Main sequence
	// ------------------------------------------------
	initial begin
		int s0;
		sys_rst = 1'b1;
		{ext_rst_pin, wdt_timeout, wdt_clear, wdt_enable} = '0;
		{wdt_rst_enable, send_tx, send_rx, raise_int} = '0;
		req = '0;
		void'($urandom(32'h5127d1a1));
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		rd(PMC_ADDR_PMR, 8'h40, 8'he0);
		rd(8'h00, 8'h00, 8'hff);
		gap(16'h0004);
		// Slow rates only ever entered from divide by four
		for (int i = 0; i < 5; i++) begin
			wr(PMC_ADDR_PMR, {cd[i], 1'b0, 5'($urandom)});
			gap(gp[i]);
		end
		for (int i = 0; i < 2; i++) begin
			wr(PMC_ADDR_PMR, 8'ha0);
			gap(16'h0040);
			send_tx <= (i == 0);
			send_rx <= (i == 1);
			@(posedge clk_sys);
			send_tx <= 1'b0;
			send_rx <= 1'b0;
			// Divide write lands while the port is busy, after the trigger
			@(posedge clk_sys);
			wr(PMC_ADDR_PMR, 8'ha0);
			gap(16'h0004);
			// Let serial activity die out before the next write
			repeat (20) @(posedge clk_sys);
		end
		wr(PMC_ADDR_POWER_CONTROL_REG, 8'h01);
		check("idle", 16'h0001, 16'(idle_active));
		raise_int <= 1'b1;
		@(posedge clk_sys);
		raise_int <= 1'b0;
		repeat ($urandom_range(3, 6)) @(posedge clk_sys);
		check("idle", 16'h0000, 16'(idle_active));
		rd(PMC_ADDR_POWER_CONTROL_REG, 8'h00, 8'h01);
		wr(PMC_ADDR_PMR, 8'h80);
		gap(16'h0040);
		wr(PMC_ADDR_POWER_CONTROL_REG, 8'h01);
		s0 = skip_n;
		ext_rst_pin <= 1'b1;
		repeat (12) @(posedge clk_sys);
		ext_rst_pin <= 1'b0;
		repeat (12) @(posedge clk_sys);
		check("skip", 16'h0001, 16'(skip_n > s0));
		check("idle", 16'h0000, 16'(idle_active));
		gap(16'h0004);
		wdt_enable     <= 1'b1;
		wdt_rst_enable <= 1'b1;
		wr(PMC_ADDR_POWER_CONTROL_REG, 8'h01);
		for (int i = 0; i < 2; i++) begin
			s0 = rst_n;
			wdt_timeout <= 1'b1;
			@(posedge clk_sys);
			wdt_timeout <= 1'b0;
			repeat (4) @(posedge clk_sys);
			check("idle", 16'h0000, 16'(idle_active));
			wdt_clear <= (i == 1);
			@(posedge clk_sys);
			wdt_clear <= 1'b0;
			repeat (530) @(posedge clk_sys);
			check("wdrst", 16'(i == 0), 16'(rst_n > s0));
		end
		wr(PMC_ADDR_STATUS, 8'h08);
		check("amp", 16'h0001, 16'(crystal_amp_disable));
		wr(PMC_ADDR_EXT_INT_FLAG_REG, 8'h08);
		repeat (20) @(posedge clk_sys);
		check("osc", 16'h0000, 16'(osc_source_indicator));
		// Amplifier restarted before crystal select
		wr(PMC_ADDR_STATUS, 8'h00);
		repeat (20) @(posedge clk_sys);
		rd(PMC_ADDR_STATUS, 8'h10, 8'h18);
		wr(PMC_ADDR_EXT_INT_FLAG_REG, 8'h08);
		repeat (20) @(posedge clk_sys);
		check("osc", 16'h0001, 16'(osc_source_indicator));
		rd(PMC_ADDR_EXT_INT_FLAG_REG, 8'h0c, 8'h0c);
		test_done();
	end
endmodule // testbench

// [verilog/pmc_pkg.sv]
// Constants and carrier types for the power mode and clock control block.
// Assumes a single system clock and a simple strobe register port.
//
// Summary of operation
// - Writing one to power control bit 0 enters idle after that write.
// - Idle stops the CPU clock; peripheral clocks keep running.
// - In idle, address latch and program store strobes are high; ports hold.
// - Any enabled interrupt clears idle bit and ends idle.
// - External reset needs eight clocks high (two divide-by-4 machine cycles) at any divide rate; resets idle and state.
// - Watchdog timeout wakes idle; reset follows 512 clocks unless cleared.
// - Divide select bits 7:6 pick 4, 64 or 1024 clocks per machine cycle.
// - Economy peripherals share core rate; in idle they run at clock/4.
// - New divide selection takes effect one instruction cycle after write.
// - Oscillator select bit 3 picks source; bit 2 reports it; one cycle delay.
// - Crystal warm flag set by hardware; crystal select refused while clear.
// - Switchback enable returns core to divide-by-4 on serial or external interrupt acknowledge.
// - Receive start edge or transmit buffer write triggers switchback.
// - Switchback ignores serial interrupt flags.
// - Divide writes ignored during serial activity with switchback enabled.
// - Watchdog, power-on or external reset forces divide-by-4.

package pmc_pkg;

	// ------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------
	localparam logic [7:0] PMC_ADDR_POWER_CONTROL_REG   = 8'h87;
	localparam logic [7:0] PMC_ADDR_EXT_INT_FLAG_REG   = 8'h91;
	localparam logic [7:0] PMC_ADDR_PMR    = 8'hc4;
	localparam logic [7:0] PMC_ADDR_STATUS = 8'hc5;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int PMC_IDLE_BIT    = 0;
	localparam int PMC_CD_LO_BIT   = 6;
	localparam int PMC_CD_HI_BIT   = 7;
	localparam int PMC_SWB_BIT     = 5;
	localparam int PMC_CRYSTAL_AMP_DISABLE_BIT   = 3;
	localparam int PMC_OSCSEL_BIT  = 3;
	localparam int PMC_OSCIND_BIT  = 2;
	localparam int PMC_XTWARM_BIT  = 4;

	// ------------------------------------------------------------
	// Divide codes and reset values
	// ------------------------------------------------------------
	localparam logic [1:0] PMC_CD_RSVD  = 2'h0;
	localparam logic [1:0] PMC_CD_DIV4  = 2'h1;
	localparam logic [1:0] PMC_CD_DIV64 = 2'h2;
	localparam logic [1:0] PMC_CD_DIV1K = 2'h3;
	localparam logic [1:0] PMC_CD_RESET = PMC_CD_DIV4;

	localparam int PMC_CLK_DIV4  = 4;
	localparam int PMC_CLK_DIV64 = 64;
	localparam int PMC_CLK_DIV1K = 1024;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int PMC_CLK_PERIOD_NS    = 10;
	localparam int PMC_RST_MIN_MC       = 2;
	localparam int PMC_RST_MIN_CLOCKS   = PMC_RST_MIN_MC * PMC_CLK_DIV4;
	localparam int PMC_WDT_RST_CLOCKS   = 512;
	localparam int PMC_XTAL_WARM_CLOCKS = 256;

	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} pmc_req_type;

	// Serial and interrupt events into the block
	typedef struct packed {
		logic rx_start_fall;
		logic rx_enable;
		logic tx_buf_write;
		logic serial_busy;
		logic ext_int_ack;
		logic any_int;
	} pmc_evt_type;

endpackage

// [verilog/pmc_power_ctrl.sv]
// Idle entry and exit, economy divider, oscillator select, switchback.
// Assumes CPU, interrupt controller and serial port share clk_sys.
`timescale 1ns/1ps

module pmc_power_ctrl
	import pmc_pkg::*;
#(
	parameter int XTAL_WARM_CLOCKS = PMC_XTAL_WARM_CLOCKS
) (
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        ext_rst_pin,
	input  wire logic        wdt_timeout,
	input  wire logic        wdt_clear,
	input  wire logic        wdt_enable,
	input  wire logic        wdt_rst_enable,
	input  wire logic        ext_int_pending,
	input  wire pmc_req_type req,
	input  wire pmc_evt_type evt,
	output logic [7:0]       rdata,
	output logic             cpu_clk_en,
	output logic             periph_tick,
	output logic             core_tick,
	output logic             idle_active,
	output logic             addr_latch_strobe,
	output logic             program_store_strobe,
	output logic             port_hold,
	output logic             core_rst,
	output logic             skip_next_instr,
	output logic             osc_source_indicator,
	output logic             crystal_amp_disable
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PMC_RUN  = 2'b00,
		PMC_IDLE = 2'b01
	} pmc_mode_type;

	pmc_mode_type mode_q, mode_d;
	logic [1:0]   cd_act_q, cd_act_d;
	logic [1:0]   cd_pend_q, cd_pend_d;
	logic         cd_wait_q, cd_wait_d;
	logic         swb_q, swb_d;
	logic         osc_sel_q, osc_sel_d;
	logic         osc_ind_q, osc_ind_d;
	logic         osc_wait_q, osc_wait_d;
	logic         crystal_amp_disable_q, crystal_amp_disable_d;
	logic         xtwarm_q, xtwarm_d;
	logic [15:0]  warm_cnt_q, warm_cnt_d;
	logic [3:0]   rst_cnt_q, rst_cnt_d;
	logic [9:0]   wdt_cnt_q, wdt_cnt_d;
	logic         wdt_arm_q, wdt_arm_d;
	logic         core_rst_q, core_rst_d;
	logic         skip_q, skip_d;
	logic [7:0]   rdata_q, rdata_d;
	logic         cpu_en_q, cpu_en_d;
	logic         ptick_q, ptick_d;
	logic         ctick_q, ctick_d;
	logic         idle_q, idle_d;
	logic         div_tick;
	logic         div4_tick;
	logic [1:0]   div_code;

	function automatic logic is_wr(input pmc_req_type r,
		input logic [7:0] a);
		is_wr = r.wr && (r.addr == a);
	endfunction

	// ------------------------------------------------------------
	// Machine cycle dividers
	// ------------------------------------------------------------
	assign div_code = cd_act_q;

	pmc_rate_div u_core_div (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.div_code (div_code),
		.tick     (div_tick)
	);

	pmc_rate_div u_idle_div (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.div_code (PMC_CD_DIV4),
		.tick     (div4_tick)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic swb_evt;
		logic cd_wr_ok;
		logic [1:0] cd_new;
		logic rst_req;
		swb_evt  = 1'b0;
		cd_wr_ok = 1'b0;
		cd_new   = 2'h0;
		rst_req  = 1'b0;
		mode_d     = mode_q;
		cd_act_d   = cd_act_q;
		cd_pend_d  = cd_pend_q;
		cd_wait_d  = cd_wait_q;
		swb_d      = swb_q;
		osc_sel_d  = osc_sel_q;
		osc_ind_d  = osc_ind_q;
		osc_wait_d = osc_wait_q;
		crystal_amp_disable_d    = crystal_amp_disable_q;
		xtwarm_d   = xtwarm_q;
		warm_cnt_d = warm_cnt_q;
		rst_cnt_d  = rst_cnt_q;
		wdt_cnt_d  = wdt_cnt_q;
		wdt_arm_d  = wdt_arm_q;
		skip_d     = 1'b0;
		rdata_d    = 8'h00;

		if (ext_rst_pin) begin
			if (rst_cnt_q < 4'(PMC_RST_MIN_CLOCKS))
				rst_cnt_d = rst_cnt_q + 4'h1;
		end else begin
			rst_cnt_d = 4'h0;
		end
		rst_req = ext_rst_pin && (rst_cnt_q >= 4'(PMC_RST_MIN_CLOCKS - 1));

		// watchdog reset delay; a new time-out beats a clear unless already armed
		if (wdt_timeout && wdt_rst_enable && !wdt_arm_q) begin
			wdt_arm_d = 1'b1;
			wdt_cnt_d = 10'h000;
		end else if (wdt_clear) begin
			wdt_arm_d = 1'b0;
			wdt_cnt_d = 10'h000;
		end else if (wdt_arm_q) begin
			wdt_cnt_d = wdt_cnt_q + 10'h001;
			if (wdt_cnt_q == 10'(PMC_WDT_RST_CLOCKS - 1))
				rst_req = 1'b1;
		end
		core_rst_d = rst_req;

		if (crystal_amp_disable_q) begin
			warm_cnt_d = 16'h0000;
			xtwarm_d   = 1'b0;
		end else if (!xtwarm_q) begin
			warm_cnt_d = warm_cnt_q + 16'h0001;
			if (warm_cnt_q == 16'(XTAL_WARM_CLOCKS - 1))
				xtwarm_d = 1'b1;
		end

		swb_evt = swb_q && ((evt.rx_start_fall && evt.rx_enable)
			|| evt.tx_buf_write || evt.ext_int_ack);

		cd_new = req.wdata[PMC_CD_HI_BIT:PMC_CD_LO_BIT];
		cd_wr_ok = is_wr(req, PMC_ADDR_PMR)
			&& !(swb_q && evt.serial_busy)
			&& (cd_new != PMC_CD_RSVD);
		if (is_wr(req, PMC_ADDR_PMR))
			swb_d = req.wdata[PMC_SWB_BIT];
		if (cd_wr_ok) begin
			cd_pend_d = cd_new;
			cd_wait_d = 1'b1;
		end else if (cd_wait_q && div_tick) begin
			cd_act_d  = cd_pend_q;
			cd_wait_d = 1'b0;
		end
		if (swb_evt) begin
			cd_act_d  = PMC_CD_DIV4;
			cd_pend_d = PMC_CD_DIV4;
			cd_wait_d = 1'b0;
		end

		if (is_wr(req, PMC_ADDR_EXT_INT_FLAG_REG)) begin
			if (!req.wdata[PMC_OSCSEL_BIT] || xtwarm_q) begin
				osc_sel_d  = req.wdata[PMC_OSCSEL_BIT];
				osc_wait_d = 1'b1;
			end
		end else if (osc_wait_q && div_tick) begin
			osc_ind_d  = osc_sel_q;
			osc_wait_d = 1'b0;
		end
		if (is_wr(req, PMC_ADDR_STATUS))
			crystal_amp_disable_d = req.wdata[PMC_CRYSTAL_AMP_DISABLE_BIT] && !osc_ind_q;

		case (mode_q)
			PMC_RUN: begin
				if (is_wr(req, PMC_ADDR_POWER_CONTROL_REG) && req.wdata[PMC_IDLE_BIT])
					mode_d = PMC_IDLE;
			end
			PMC_IDLE: begin
				if (evt.any_int || ext_int_pending
					|| (wdt_timeout && wdt_enable))
					mode_d = PMC_RUN;
				// reset out of idle skips next instruction
				if (rst_req) begin
					mode_d = PMC_RUN;
					skip_d = 1'b1;
				end
			end
			default: mode_d = PMC_RUN;
		endcase

		// Read port
		if (req.rd) begin
			case (req.addr)
				PMC_ADDR_POWER_CONTROL_REG:
					rdata_d[PMC_IDLE_BIT] = (mode_q == PMC_IDLE);
				PMC_ADDR_PMR: begin
					rdata_d[PMC_CD_HI_BIT:PMC_CD_LO_BIT] = cd_act_q;
					rdata_d[PMC_SWB_BIT] = swb_q;
				end
				PMC_ADDR_EXT_INT_FLAG_REG: begin
					rdata_d[PMC_OSCSEL_BIT] = osc_sel_q;
					rdata_d[PMC_OSCIND_BIT] = osc_ind_q;
				end
				PMC_ADDR_STATUS: begin
					rdata_d[PMC_XTWARM_BIT] = xtwarm_q;
					rdata_d[PMC_CRYSTAL_AMP_DISABLE_BIT]  = crystal_amp_disable_q;
				end
				default: rdata_d = 8'h00;
			endcase
		end

		idle_d   = (mode_d == PMC_IDLE);
		cpu_en_d = !idle_d;
		ptick_d  = idle_d ? div4_tick : div_tick;
		ctick_d  = div_tick && !idle_d;

		if (rst_req) begin
			cd_act_d  = PMC_CD_RESET;
			cd_pend_d = PMC_CD_RESET;
			cd_wait_d = 1'b0;
			swb_d     = 1'b0;
			wdt_arm_d = 1'b0;
			wdt_cnt_d = 10'h000;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			mode_q     <= PMC_RUN;
			cd_act_q   <= PMC_CD_RESET;
			cd_pend_q  <= PMC_CD_RESET;
			cd_wait_q  <= 1'b0;
			swb_q      <= 1'b0;
			osc_sel_q  <= 1'b0;
			osc_ind_q  <= 1'b0;
			osc_wait_q <= 1'b0;
			crystal_amp_disable_q    <= 1'b0;
			xtwarm_q   <= 1'b0;
			warm_cnt_q <= 16'h0000;
			rst_cnt_q  <= 4'h0;
			wdt_cnt_q  <= 10'h000;
			wdt_arm_q  <= 1'b0;
			core_rst_q <= 1'b0;
			skip_q     <= 1'b0;
			rdata_q    <= 8'h00;
			cpu_en_q   <= 1'b1;
			ptick_q    <= 1'b0;
			ctick_q    <= 1'b0;
			idle_q     <= 1'b0;
		end else begin
			mode_q     <= mode_d;
			cd_act_q   <= cd_act_d;
			cd_pend_q  <= cd_pend_d;
			cd_wait_q  <= cd_wait_d;
			swb_q      <= swb_d;
			osc_sel_q  <= osc_sel_d;
			osc_ind_q  <= osc_ind_d;
			osc_wait_q <= osc_wait_d;
			crystal_amp_disable_q    <= crystal_amp_disable_d;
			xtwarm_q   <= xtwarm_d;
			warm_cnt_q <= warm_cnt_d;
			rst_cnt_q  <= rst_cnt_d;
			wdt_cnt_q  <= wdt_cnt_d;
			wdt_arm_q  <= wdt_arm_d;
			core_rst_q <= core_rst_d;
			skip_q     <= skip_d;
			rdata_q    <= rdata_d;
			cpu_en_q   <= cpu_en_d;
			ptick_q    <= ptick_d;
			ctick_q    <= ctick_d;
			idle_q     <= idle_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign rdata                = rdata_q;
	assign cpu_clk_en           = cpu_en_q;
	assign periph_tick          = ptick_q;
	assign core_tick            = ctick_q;
	assign idle_active          = idle_q;
	// strobes high and ports held in idle
	assign addr_latch_strobe    = idle_q;
	assign program_store_strobe = idle_q;
	assign port_hold            = idle_q;
	assign core_rst             = core_rst_q;
	assign skip_next_instr      = skip_q;
	assign osc_source_indicator = osc_ind_q;
	assign crystal_amp_disable  = crystal_amp_disable_q;

endmodule // pmc_power_ctrl

// [verilog/pmc_rate_div.sv]
// Machine cycle divider producing a one-clock tick every N clocks.
// Assumes the divide code is stable between ticks.
`timescale 1ns/1ps

module pmc_rate_div
	import pmc_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic [1:0] div_code,
	output logic            tick
);

	logic [9:0] cnt_q;
	logic [9:0] cnt_d;
	logic       tick_q;
	logic       tick_d;

	function automatic logic [9:0] last_count(input logic [1:0] code);
		case (code)
			PMC_CD_DIV64: last_count = 10'(PMC_CLK_DIV64 - 1);
			PMC_CD_DIV1K: last_count = 10'(PMC_CLK_DIV1K - 1);
			default:      last_count = 10'(PMC_CLK_DIV4 - 1);
		endcase
	endfunction

	always_comb begin
		tick_d = 1'b0;
		cnt_d  = cnt_q + 10'h001;
		if (cnt_q >= last_count(div_code)) begin
			cnt_d  = 10'h000;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q  <= 10'h000;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;

endmodule // pmc_rate_div
